// [design/tbocc_pkg.sv]
// Purpose: Constants and types for the T1 bit-oriented code controller
// Assumes: 8-bit register port, registers at their printed offsets
// Notes:   Field positions follow the code control and status layouts
package tbocc_pkg;
  // Register offsets
  localparam logic [7:0] OFF_EVT_STATUS = 8'h18;
  localparam logic [7:0] OFF_EVT_MASK   = 8'h19;
  localparam logic [7:0] OFF_CODE_CTL   = 8'h1f;
  localparam logic [7:0] OFF_RX_BYTE    = 8'h50;
  localparam logic [7:0] OFF_TX_BYTE    = 8'h51;
  localparam logic [7:0] OFF_MATCH_1    = 8'h52;
  localparam logic [7:0] OFF_MATCH_2    = 8'h53;
  // Code control fields
  localparam int CTL_SEND    = 0;
  localparam int CTL_FILT_LO = 1;
  localparam int CTL_FILT_HI = 2;
  localparam int CTL_RX_RST  = 3;
  localparam int CTL_RX_EN   = 4;
  localparam logic [7:0] CTL_USED_MASK = 8'h1f;
  // Event status fields
  localparam int EV_CODE_CHG = 0;
  localparam int EV_MATCH    = 1;
  localparam int EV_TX_EMPTY = 2;
  localparam int EV_RX_FULL  = 3;
  localparam int EV_ABORT    = 4;
  localparam int EV_CLEAR    = 5;
  localparam int EV_CLK_LOSS = 6;
  localparam int EV_AIS_CI   = 7;
  // Reset values and code framing
  localparam logic [7:0] RST_REG     = 8'h00;
  localparam logic [5:0] CODE_PRESET = 6'h3f;
  localparam logic [7:0] FLAG_ONES   = 8'hff;
  // Filter repetition counts for settings 00, 01, 10, 11
  localparam logic [2:0] FILT_N0 = 3'h1;
  localparam logic [2:0] FILT_N1 = 3'h3;
  localparam logic [2:0] FILT_N2 = 3'h5;
  localparam logic [2:0] FILT_N3 = 3'h7;
  // Bit counts on the data link, and the clock-loss count in prescaled master clock ticks
  localparam logic [3:0] ABORT_ONES = 4'h8;
  localparam logic [4:0] CLEAR_BITS = 5'h1e;
  localparam logic [3:0] CLK_LOSS_N = 4'hf;
  localparam logic [3:0] CODE_LAST  = 4'hf;
  localparam logic [3:0] BYTE_LAST  = 4'h7;

  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_CODE, TX_ABORT} tbocc_tx_t;

  // Whole state of the controller
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] mask;
    logic [7:0] match1;
    logic [7:0] match2;
    logic [7:0] tx_byte;
    logic       tx_full;
    logic [7:0] status;
    tbocc_tx_t  tx_st;
    logic [15:0] tx_sh;
    logic [3:0] tx_cnt;
    logic       tx_bit;
    logic [15:0] rx_sh;
    logic [7:0] rx_asm;
    logic [2:0] rx_bcnt;
    logic [7:0] rx_byte;
    logic [5:0] code;
    logic [5:0] last_code;
    logic [2:0] rep;
    logic [3:0] ones;
    logic [4:0] since_abort;
    logic       transmit_clock_input_q;
    logic [3:0] loss_cnt;
    logic [7:0] rd_data;
    logic       irq;
  } tbocc_state_t;
endpackage : tbocc_pkg

// [design/tbocc_top.sv]
// Purpose: T1 bit-oriented code generator, detector and link event flags
// Assumes: One data-link bit slot per i_fdl_tick; all inputs except i_rst_n synchronous
// Notes:   Events latch until the status register is read
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module tbocc_top
  import tbocc_pkg::*;
(
  input  wire logic       i_clk,      // 100 MHz system clock
  input  wire logic       i_rst_n,    // Async reset, active low
  input  wire logic [7:0] i_addr,     // Register offset
  input  wire logic [7:0] i_wr_data,  // Register write data
  input  wire logic       i_wr,       // Write strobe
  input  wire logic       i_rd,       // Read strobe
  input  wire logic       i_t1_mode,  // Line runs in T1 mode
  input  wire logic       i_fdl_tick, // One pulse per data-link bit slot
  input  wire logic       i_rx_bit,   // Received data-link bit
  input  wire logic       i_transmit_clock_input,     // Transmit clock level
  input  wire logic       i_mclk_tick,// Prescaled master clock pulse
  input  wire logic       i_ais_ci,   // Customer alarm pattern seen
  output logic [7:0]      o_rd_data,  // Read data, cycle after i_rd
  output logic            o_tx_bit,   // Outgoing data-link bit
  output logic            o_irq       // Any unmasked flag set
);

  tbocc_state_t r;
  tbocc_state_t next_r;

  logic [7:0]  ev_set;
  logic [2:0]  need;
  logic        code_on;
  logic        rx_code_on;
  logic        rx_rst_edge;
  logic        seen;
  logic [5:0]  seen_code;
  logic [15:0] code_word;
  logic [7:0]  full_byte;
  logic [2:0]  rep_new;

  // Repetitions required by the filter setting
  always_comb
  begin
    unique case ({r.ctl[CTL_FILT_HI], r.ctl[CTL_FILT_LO]})
      2'b00: need = FILT_N0;
      2'b01: need = FILT_N1;
      2'b10: need = FILT_N2;
      2'b11: need = FILT_N3;
    endcase
  end

  // Code framing: eight ones, zero, six code bits, zero
  assign code_word   = {1'b0, r.tx_byte[5:0], 1'b0, FLAG_ONES};
  assign code_on     = r.ctl[CTL_SEND] & i_t1_mode;
  assign rx_code_on  = r.ctl[CTL_RX_EN] & i_t1_mode;
  assign rx_rst_edge = i_wr & (i_addr == OFF_CODE_CTL)
                     & i_wr_data[CTL_RX_RST] & ~r.ctl[CTL_RX_RST];
  // Oldest bit sits in rx_sh[0]; a full frame is flag, 0, code, 0
  assign seen        = (r.rx_sh[7:0] == FLAG_ONES) & ~r.rx_sh[8]
                     & ~r.rx_sh[15];
  assign seen_code   = r.rx_sh[14:9];
  assign full_byte   = {i_rx_bit, r.rx_asm[7:1]};
  assign rep_new     = (seen_code != r.last_code) ? 3'h1 :
                       (r.rep == FILT_N3) ? r.rep : r.rep + 3'h1;

  always_comb
  begin
    next_r = r;
    ev_set = '0;

    // Register writes; unused control bits are not stored
    if (i_wr)
    begin
      unique case (i_addr)
        OFF_EVT_MASK: next_r.mask   = i_wr_data;
        OFF_CODE_CTL: next_r.ctl    = i_wr_data & CTL_USED_MASK;
        OFF_MATCH_1:  next_r.match1 = i_wr_data;
        OFF_MATCH_2:  next_r.match2 = i_wr_data;
        OFF_TX_BYTE:  next_r.tx_byte = i_wr_data;
        default:      next_r.tx_full = r.tx_full;
      endcase
    end

    // Transmit serializer, one bit per slot, LSB first
    if (i_fdl_tick)
    begin
      if (r.tx_st != TX_IDLE && r.tx_cnt != 4'h0)
      begin
        next_r.tx_bit = r.tx_sh[0];
        next_r.tx_sh  = {1'b1, r.tx_sh[15:1]};
        next_r.tx_cnt = r.tx_cnt - 4'h1;
      end
      else if (code_on)
      begin
        next_r.tx_st  = TX_CODE;
        next_r.tx_bit = code_word[0];
        next_r.tx_sh  = {1'b1, code_word[15:1]};
        next_r.tx_cnt = CODE_LAST;
      end
      else if (r.tx_st == TX_CODE)
      begin
        next_r.tx_st  = TX_ABORT;
        next_r.tx_bit = 1'b1;
        next_r.tx_sh  = {8'h00, FLAG_ONES};
        next_r.tx_cnt = BYTE_LAST;
      end
      else if (r.tx_full)
      begin
        next_r.tx_st   = TX_DATA;
        next_r.tx_bit  = r.tx_byte[0];
        next_r.tx_sh   = {8'hff, r.tx_byte};
        next_r.tx_sh   = {1'b1, next_r.tx_sh[15:1]};
        next_r.tx_cnt  = BYTE_LAST;
        next_r.tx_full = 1'b0;
        ev_set[EV_TX_EMPTY] = 1'b1;
      end
      else
      begin
        next_r.tx_st  = TX_IDLE;
        next_r.tx_bit = 1'b1;
      end
    end
    // Fresh send_code cuts the word, even one loaded in this slot,
    // so the code is never held back behind a pending data byte
    if (i_wr && i_addr == OFF_CODE_CTL && i_wr_data[CTL_SEND]
        && !r.ctl[CTL_SEND])
    begin
      next_r.tx_st  = TX_IDLE;
      next_r.tx_cnt = 4'h0;
    end
    // A host write refills the buffer and wins over its unload
    if (i_wr && i_addr == OFF_TX_BYTE)
      next_r.tx_full = 1'b1;

    // Receive side: byte assembly, abort and clear counting
    if (i_fdl_tick)
    begin
      next_r.rx_sh   = {i_rx_bit, r.rx_sh[15:1]};
      next_r.rx_asm  = full_byte;
      next_r.rx_bcnt = r.rx_bcnt + 3'h1;
      if (r.rx_bcnt == BYTE_LAST[2:0])
      begin
        next_r.rx_byte = full_byte;
        ev_set[EV_RX_FULL] = 1'b1;
        if (full_byte == r.match1 || full_byte == r.match2)
          ev_set[EV_MATCH] = 1'b1;
      end
      if (!i_rx_bit)
        next_r.ones = 4'h0;
      else if (r.ones != ABORT_ONES)
        next_r.ones = r.ones + 4'h1;
      if (i_rx_bit && r.ones == ABORT_ONES - 4'h1)
      begin
        ev_set[EV_ABORT]   = 1'b1;
        next_r.since_abort = 5'h0;
      end
      else if (r.since_abort != CLEAR_BITS)
      begin
        next_r.since_abort = r.since_abort + 5'h1;
        if (r.since_abort == CLEAR_BITS - 5'h1)
          ev_set[EV_CLEAR] = 1'b1;
      end
    end

    // Code detector with repetition filter
    if (!rx_code_on || rx_rst_edge)
    begin
      next_r.code      = CODE_PRESET;
      next_r.last_code = CODE_PRESET;
      next_r.rep       = 3'h0;
    end
    else if (i_fdl_tick && seen)
    begin
      next_r.last_code = seen_code;
      next_r.rep       = rep_new;
      if (rep_new >= need && seen_code != r.code)
      begin
        next_r.code = seen_code;
        ev_set[EV_CODE_CHG] = 1'b1;
      end
    end

    // Transmit clock watchdog on prescaled ticks
    next_r.transmit_clock_input_q = i_transmit_clock_input;
    if (i_transmit_clock_input != r.transmit_clock_input_q)
      next_r.loss_cnt = 4'h0;
    else if (i_mclk_tick && r.loss_cnt != CLK_LOSS_N)
    begin
      next_r.loss_cnt = r.loss_cnt + 4'h1;
      if (r.loss_cnt == CLK_LOSS_N - 4'h1)
        ev_set[EV_CLK_LOSS] = 1'b1;
    end

    ev_set[EV_AIS_CI] = i_ais_ci & i_t1_mode;

    // Read data; code mode hides raw byte and upper bits
    next_r.rd_data = 8'h00;
    if (i_rd)
    begin
      unique case (i_addr)
        OFF_EVT_STATUS: next_r.rd_data = r.status;
        OFF_EVT_MASK:   next_r.rd_data = r.mask;
        OFF_CODE_CTL:   next_r.rd_data = r.ctl;
        OFF_RX_BYTE:    next_r.rd_data = rx_code_on ? {2'b00, r.code}
                                                    : r.rx_byte;
        OFF_TX_BYTE:    next_r.rd_data = r.tx_byte;
        OFF_MATCH_1:    next_r.rd_data = r.match1;
        OFF_MATCH_2:    next_r.rd_data = r.match2;
        default:        next_r.rd_data = 8'h00;
      endcase
    end

    // Read clears flags, but a new event in the same cycle survives
    if (i_rd && i_addr == OFF_EVT_STATUS)
      next_r.status = ev_set;
    else
      next_r.status = r.status | ev_set;
    next_r.irq = |(next_r.status & r.mask);
    if (i_wr && i_addr == OFF_EVT_MASK)
      next_r.irq = |(next_r.status & i_wr_data);
  end

  // State register; all host registers clear on reset
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r           <= '0;
      r.tx_st     <= TX_IDLE;
      r.tx_bit    <= 1'b1;
      r.code      <= CODE_PRESET;
      r.last_code <= CODE_PRESET;
    end
    else
      r <= next_r;
  end

  assign o_rd_data = r.rd_data;
  assign o_tx_bit  = r.tx_bit;
  assign o_irq     = r.irq;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_code_start;
    i_fdl_tick && code_on && (r.tx_st == TX_IDLE || r.tx_cnt == 4'h0)
    |=> r.tx_st == TX_CODE && r.tx_cnt == CODE_LAST;
  endproperty
  a_code_start: assert property (p_code_start)
    else $error("code not started at first slot");

  property p_send_arm;
    i_wr && i_addr == OFF_CODE_CTL && i_wr_data[CTL_SEND]
      && !r.ctl[CTL_SEND]
    |=> r.tx_st == TX_IDLE && r.tx_cnt == 4'h0;
  endproperty
  a_send_arm: assert property (p_send_arm)
    else $error("send_code did not cut the current word");

  property p_abort_after;
    r.tx_st == TX_CODE && r.tx_cnt == 4'h0 && i_fdl_tick && !code_on
      && !(i_wr && i_addr == OFF_CODE_CTL)
    |=> r.tx_st == TX_ABORT && r.tx_bit;
  endproperty
  a_abort_after: assert property (p_abort_after)
    else $error("no abort after code");

  property p_hide_upper;
    i_rd && i_addr == OFF_RX_BYTE && rx_code_on |=> o_rd_data[7:6] == 2'b00;
  endproperty
  a_hide_upper: assert property (p_hide_upper)
    else $error("upper receive bits not zero");

  property p_preset;
    !rx_code_on |=> r.code == CODE_PRESET;
  endproperty
  a_preset: assert property (p_preset)
    else $error("code not preset to ones");

  property p_filter;
    ev_set[EV_CODE_CHG] |-> rep_new >= need && rx_code_on;
  endproperty
  a_filter: assert property (p_filter)
    else $error("code accepted too early");

  property p_abort_rx;
    (i_fdl_tick && i_rx_bit && r.ones == 4'h7) |=> r.status[EV_ABORT];
  endproperty
  a_abort_rx: assert property (p_abort_rx)
    else $error("abort event missing");

  property p_read_status;
    i_rd && i_addr == OFF_EVT_STATUS |=> o_rd_data == $past(r.status);
  endproperty
  a_read_status: assert property (p_read_status)
    else $error("status read wrong");

  property p_sticky;
    r.status[EV_MATCH] && !(i_rd && i_addr == OFF_EVT_STATUS)
    |=> r.status[EV_MATCH];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without read");

  property p_irq;
    ##1 $past(|(r.status & r.mask)) && !$past(i_rd) && !$past(i_wr)
    |-> o_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq missing for unmasked flag");

  property p_t1_only;
    !i_t1_mode |-> !ev_set[EV_CODE_CHG] && !ev_set[EV_AIS_CI];
  endproperty
  a_t1_only: assert property (p_t1_only)
    else $error("code event outside T1");

  c_code_change: cover property (r.status[EV_CODE_CHG]);
  c_tx_empty:    cover property (r.status[EV_TX_EMPTY]);
  c_clk_loss:    cover property (r.status[EV_CLK_LOSS]);
  c_abort_tx:    cover property (r.tx_st == TX_ABORT);

endmodule : tbocc_top

// [verification/tbocc_far_end.sv]
// Purpose: Far-end link model that feeds received data-link bits
// Assumes: One bit slot per tick pulse; bits are queued by the bench
// Notes:   Sends the idle level whenever nothing is queued
`timescale 1ns/1ps
module tbocc_far_end
(
  input  wire logic i_clk,      // System clock
  input  wire logic i_fdl_tick, // Bit slot pulse
  output logic      o_rx_bit    // Bit toward the receiver
);
  logic q[$];
  logic idle_bit = 1'b1;
  initial o_rx_bit = 1'b1;
  // Launched on the slot edge so the bit holds for the whole next slot
  always @(posedge i_clk)
    if (i_fdl_tick)
      o_rx_bit <= (q.size() != 0) ? q.pop_front() : idle_bit;
  // One code frame: eight ones, zero, code LSB first, zero
  task automatic send_frame(input logic [5:0] code);
    logic [15:0] w;
    w = {1'b0, code, 1'b0, 8'hff};
    for (int i = 0; i < 16; i++)
      q.push_back(w[i]);
  endtask : send_frame
  task automatic send_bit(input logic b);
    q.push_back(b);
  endtask : send_bit
  // Checked on falling edges to stay clear of the pop on the slot edge
  task automatic drain(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 800 && !ok; i++)
    begin
      @(negedge i_clk);
      ok = (q.size() == 0) && i_fdl_tick;
    end
    @(posedge i_clk);
  endtask : drain
endmodule : tbocc_far_end

// [verification/tbocc_top_tb.sv]
// Purpose: Self-checking bench for the bit-oriented code controller
// Assumes: Slot pulse every 4 cycles, prescaled clock pulse every 8
// Notes:   Tx bits are sampled just after the slot edge that sets them
`timescale 1ns/1ps
module tbocc_top_tb
  import tbocc_pkg::*;
;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [7:0]  i_wr_data = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_t1_mode = 1'b1;
  logic        i_fdl_tick = 1'b0;
  logic        i_transmit_clock_input = 1'b0;
  logic        i_mclk_tick = 1'b0;
  logic        i_ais_ci = 1'b0;
  logic        transmit_clock_input_run = 1'b1;
  logic        rx_bit;
  logic [7:0]  o_rd_data;
  logic        o_tx_bit;
  logic        o_irq;
  int          cyc = 0;
  int          fails = 0;
  int          n_tests = 0;
  logic [7:0]  d;
  logic [31:0] got;
  logic        ok;

  initial forever #5 i_clk = ~i_clk;
  // Free-running slot, prescaler and transmit clock activity
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    i_fdl_tick <= (cyc % 4 == 3);
    i_mclk_tick <= (cyc % 8 == 7);
    if (transmit_clock_input_run && cyc % 3 == 0)
      i_transmit_clock_input <= ~i_transmit_clock_input;
  end

  tbocc_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .i_t1_mode(i_t1_mode), .i_fdl_tick(i_fdl_tick), .i_rx_bit(rx_bit),
    .i_transmit_clock_input(i_transmit_clock_input), .i_mclk_tick(i_mclk_tick), .i_ais_ci(i_ais_ci),
    .o_rd_data(o_rd_data), .o_tx_bit(o_tx_bit), .o_irq(o_irq));
  tbocc_far_end far_u (.i_clk(i_clk), .i_fdl_tick(i_fdl_tick),
    .o_rx_bit(rx_bit));

  task automatic report_and_stop(input logic timed_out);
    if (timed_out)
      fails++;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Bus cycles: one-cycle strobes, read data only in the following cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rd_data;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a, d);
    chk(d, e);
  endtask : rc
  task automatic fl();
    far_u.drain(ok);
    if (!ok)
      report_and_stop(1'b1);
    // Let the detector see the last window before anything is judged
    repeat (6) @(posedge i_clk);
  endtask : fl
  // Next outgoing bit; a falling edge first so an old pulse is not reused
  task automatic tx_bit(output logic b);
    int i;
    i = 0;
    @(negedge i_clk);
    while (i_fdl_tick !== 1'b1 && i < 8)
    begin
      @(negedge i_clk);
      i++;
    end
    if (i_fdl_tick !== 1'b1)
      report_and_stop(1'b1);
    @(posedge i_clk);
    #1 b = o_tx_bit;
  endtask : tx_bit
  task automatic tx_n(input int n, output logic [31:0] v);
    logic b;
    v = '0;
    for (int i = 0; i < n; i++)
    begin
      tx_bit(b);
      v[i] = b;
    end
  endtask : tx_n

  task automatic t_regs();
    rc(OFF_EVT_STATUS, RST_REG);
    rc(OFF_EVT_MASK, RST_REG);
    rc(OFF_CODE_CTL, RST_REG);
    rc(OFF_MATCH_1, RST_REG);
    rc(OFF_MATCH_2, RST_REG);
    rc(8'h20, 8'h00);
    wr(OFF_EVT_MASK, 8'ha5);
    rc(OFF_EVT_MASK, 8'ha5);
    wr(OFF_MATCH_1, 8'h55);
    wr(OFF_MATCH_2, 8'haa);
    rc(OFF_MATCH_1, 8'h55);
    rc(OFF_MATCH_2, 8'haa);
    wr(OFF_CODE_CTL, 8'he4);
    rc(OFF_CODE_CTL, 8'h04);
    wr(OFF_EVT_MASK, 8'h00);
  endtask : t_regs
  // Outside T1 a set send bit is ignored and the byte goes out as data
  task automatic t_tx_data();
    logic b;
    i_t1_mode <= 1'b0;
    wr(OFF_CODE_CTL, 8'h01);
    rd(OFF_EVT_STATUS, d);
    wr(OFF_TX_BYTE, 8'hea);
    b = 1'b1;
    for (int i = 0; i < 24 && b; i++)
      tx_bit(b);
    tx_n(7, got);
    chk({got[6:0], b}, 8'hea);
    rd(OFF_EVT_STATUS, d);
    chk(d[EV_TX_EMPTY], 1'b1);
    wr(OFF_CODE_CTL, 8'h00);
    i_t1_mode <= 1'b1;
  endtask : t_tx_data
  task automatic t_tx_code();
    wr(OFF_TX_BYTE, 8'hea);
    wr(OFF_CODE_CTL, 8'h01);
    // Same code bits, so only a byte is left pending behind the code
    wr(OFF_TX_BYTE, 8'h6a);
    tx_n(32, got);
    chk(got, {2{1'b0, 6'h2a, 1'b0, 8'hff}});
    // Cleared on a frame boundary: abort first, then the pending byte
    wr(OFF_CODE_CTL, 8'h00);
    tx_n(16, got);
    chk(got, 32'h00006aff);
    tx_n(24, got);
    chk(got, 32'h00ffffff);
  endtask : t_tx_code
  // Every filter setting, after a receive reset, with the interrupt
  task automatic t_rx_code();
    logic [5:0] c;
    int n;
    wr(OFF_EVT_MASK, 8'h01);
    for (int f = 0; f < 4; f++)
    begin
      c = 6'(21 + f);
      n = 2 * f + 1;
      wr(OFF_CODE_CTL, 8'(16 + 2 * f));
      wr(OFF_CODE_CTL, 8'(24 + 2 * f));
      rc(OFF_RX_BYTE, {2'b00, CODE_PRESET});
      rd(OFF_EVT_STATUS, d);
      for (int k = 1; k < n; k++)
        far_u.send_frame(c);
      fl();
      chk(o_irq, 1'b0);
      far_u.send_frame(c);
      fl();
      repeat (2) @(posedge i_clk);
      chk(o_irq, 1'b1);
      rd(OFF_EVT_STATUS, d);
      chk(d[EV_CODE_CHG], 1'b1);
      rc(OFF_RX_BYTE, {2'b00, c});
      chk(o_irq, 1'b0);
    end
  endtask : t_rx_code
  // Raw bytes: match either register, full, abort count, clear count
  task automatic t_rx_byte();
    wr(OFF_CODE_CTL, 8'h00);
    far_u.idle_bit = 1'b0;
    rd(OFF_EVT_STATUS, d);
    for (int i = 0; i < 16; i++)
      far_u.send_bit(i[0] == 1'b0);
    fl();
    rd(OFF_EVT_STATUS, d);
    chk(d[EV_MATCH], 1'b1);
    chk(d[EV_RX_FULL], 1'b1);
    for (int i = 0; i < 16; i++)
      far_u.send_bit(1'b0);
    fl();
    rd(OFF_EVT_STATUS, d);
    for (int i = 0; i < 24; i++)
      far_u.send_bit(i < 7);
    fl();
    rd(OFF_EVT_STATUS, d);
    chk(d[EV_MATCH], 1'b0);
    chk(d[EV_ABORT], 1'b0);
    rc(OFF_RX_BYTE, 8'h00);
    for (int i = 0; i < 36; i++)
      far_u.send_bit(i < 8);
    fl();
    rd(OFF_EVT_STATUS, d);
    chk(d[EV_ABORT], 1'b1);
    chk(d[EV_CLEAR], 1'b0);
    far_u.send_bit(1'b0);
    far_u.send_bit(1'b0);
    fl();
    rd(OFF_EVT_STATUS, d);
    chk(d[EV_CLEAR], 1'b1);
  endtask : t_rx_byte
  task automatic t_clk_loss();
    transmit_clock_input_run <= 1'b0;
    rd(OFF_EVT_STATUS, d);
    repeat (13 * 8) @(posedge i_clk);
    rd(OFF_EVT_STATUS, d);
    chk(d[EV_CLK_LOSS], 1'b0);
    repeat (4 * 8) @(posedge i_clk);
    rd(OFF_EVT_STATUS, d);
    chk(d[EV_CLK_LOSS], 1'b1);
    transmit_clock_input_run <= 1'b1;
  endtask : t_clk_loss
  task automatic t_ais();
    for (int m = 0; m < 2; m++)
    begin
      i_t1_mode <= m[0];
      rd(OFF_EVT_STATUS, d);
      @(posedge i_clk);
      i_ais_ci <= 1'b1;
      @(posedge i_clk);
      i_ais_ci <= 1'b0;
      rd(OFF_EVT_STATUS, d);
      chk(d[EV_AIS_CI], m[0]);
    end
  endtask : t_ais

  // Guard against a hang anywhere in the sequence
  initial
  begin
    #500000;
    report_and_stop(1'b1);
  end
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_tx_data();
    t_tx_code();
    t_rx_code();
    t_rx_byte();
    t_clk_loss();
    t_ais();
    report_and_stop(1'b0);
  end
endmodule : tbocc_top_tb
